// ---- core/spc_cfg.svh ----
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// Register offsets, one byte per address
`define SPC_OFS_MULT 12'h109
`define SPC_OFS_RATE 12'h10a
`define SPC_OFS_VCO 12'h10b
`define SPC_OFS_SYNC 12'h120
`define SPC_OFS_TEST 12'h121
`define SPC_OFS_WDOG 12'h124
`define SPC_OFS_STAT 12'h130
// Reset values
`define SPC_RST_MULT 8'h14
`define SPC_RST_RATE 8'h00
`define SPC_RST_VCO 8'h00
`define SPC_RST_SYNC 8'h01
`define SPC_RST_TEST 8'h00
`define SPC_RST_WDOG 8'h00
// Legal multiplier codes
`define SPC_MULT_X4 8'h10
`define SPC_MULT_X5 8'h14
`define SPC_MULT_X8P25 8'h21
`define SPC_MULT_X10 8'h28
// Fields of the watchdog, test and rate registers
`define SPC_WD_PLL_BIT 7
`define SPC_WD_DEC_HI 5
`define SPC_WD_DEC_LO 4
`define SPC_WD_THR_HI 2
`define SPC_WD_THR_LO 0
`define SPC_TEST_HI 4
`define SPC_RATE_HI 1
// Watchdog decrement steps and thresholds (powers of two)
`define SPC_DEC_0 33'h000000001
`define SPC_DEC_1 33'h000000002
`define SPC_DEC_2 33'h000000008
`define SPC_DEC_3 33'h000000010
`define SPC_THR_1 33'h000020000
`define SPC_THR_2 33'h000080000
`define SPC_THR_3 33'h100000000
`define SPC_THR_4 33'h000800000
`define SPC_WD_ZERO 33'h000000000
`define SPC_WD_ONE 33'h000000001
`define SPC_RD_ZERO 8'h00
`endif

// ---- core/spc_pkg.sv ----
package spc_pkg;
    typedef enum logic [2:0] {
        PAT_NORMAL = 3'b000,
        PAT_PRBS7 = 3'b001,
        PAT_PRBS9 = 3'b010,
        PAT_PRBS15 = 3'b011,
        PAT_PRBS31 = 3'b100,
        PAT_RESERVED = 3'b111
    } spc_pattern_t;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_FIRE = 2'b10
    } spc_wd_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spc_bus_req_t;

    typedef struct packed {
        logic [7:0] pllFeedbackMultiplier;
        logic [1:0] lineRate;
        logic lowVcoBandSelect;
        logic syncRequestN;
        spc_pattern_t prbsTestSelect;
        logic multLegal;
    } spc_phy_cfg_t;
endpackage : spc_pkg

// ---- core/spc_phy_config_regs.sv ----
`include "spc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spc_phy_config_regs
    import spc_pkg::*;
(
    input wire logic clk, // 100 MHz register clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire spc_bus_req_t busReq, // Address, data, strobes
    output logic [7:0] rdData, // Read data, cycle after strobe
    input wire logic linkEnable, // Link enabled
    input wire logic linkUp, // Link is up
    input wire logic crcFault, // CRC fault flagged
    input wire logic linkSyncN, // Normal-link SYNC, active low
    output spc_phy_cfg_t phyCfg, // Decoded PHY configuration
    output logic syncOutN, // SYNC request to transmitter, low asserts
    output logic rxResetPulse, // One-cycle SerDes receiver reset
    output logic pllResetPulse // One-cycle SerDes PLL reset
);

    // Configuration storage
    logic [7:0] mult_q;
    logic [7:0] rate_q;
    logic [7:0] vco_q;
    logic [7:0] sync_q;
    logic [7:0] test_q;
    logic [7:0] wdog_q;

    // Per-register write enables
    logic multWr;
    logic rateWr;
    logic vcoWr;
    logic syncWr;
    logic testWr;
    logic wdogWr;

    // Watchdog
    logic [32:0] wdCnt_q;
    spc_wd_state_t wdState_q;
    logic [32:0] wdLimit;
    logic [32:0] wdStep;
    logic wdArmed;
    logic wdHealthy;
    logic wdFire;

    // Read path and decoded configuration
    logic [7:0] rdData_d;
    spc_phy_cfg_t phyCfg_d;

    function automatic logic isWrite(input spc_bus_req_t r, input logic [11:0] ofs);
        isWrite = r.wr && (r.addr == ofs);
    endfunction : isWrite

    function automatic logic isLegalMult(input logic [7:0] code);
        isLegalMult = (code == `SPC_MULT_X4) || (code == `SPC_MULT_X5)
            || (code == `SPC_MULT_X8P25) || (code == `SPC_MULT_X10);
    endfunction : isLegalMult

    // Reserved codes collapse to one value so the PHY can refuse them
    function automatic spc_pattern_t patternOf(input logic [4:0] code);
        case (code)
            5'h00: patternOf = PAT_NORMAL;
            5'h01: patternOf = PAT_PRBS7;
            5'h02: patternOf = PAT_PRBS9;
            5'h03: patternOf = PAT_PRBS15;
            5'h04: patternOf = PAT_PRBS31;
            default: patternOf = PAT_RESERVED;
        endcase
    endfunction : patternOf

    function automatic logic [7:0] statusWord(input logic running, input logic up,
        input logic en);
        statusWord = {5'h00, running, up, en};
    endfunction : statusWord

    function automatic logic [32:0] decStep(input logic [1:0] sel);
        case (sel)
            2'b00: decStep = `SPC_DEC_0;
            2'b01: decStep = `SPC_DEC_1;
            2'b10: decStep = `SPC_DEC_2;
            2'b11: decStep = `SPC_DEC_3;
            default: decStep = `SPC_DEC_0;
        endcase
    endfunction : decStep

    function automatic logic [32:0] threshold(input logic [2:0] sel);
        case (sel)
            3'd1: threshold = `SPC_THR_1;
            3'd2: threshold = `SPC_THR_2;
            3'd3: threshold = `SPC_THR_3;
            3'd4: threshold = `SPC_THR_4;
            default: threshold = `SPC_WD_ZERO;
        endcase
    endfunction : threshold

    // Unmapped addresses decode to no enable, so their writes vanish
    always_comb begin
        multWr = isWrite(busReq, `SPC_OFS_MULT);
        rateWr = isWrite(busReq, `SPC_OFS_RATE);
        vcoWr = isWrite(busReq, `SPC_OFS_VCO);
        syncWr = isWrite(busReq, `SPC_OFS_SYNC);
        testWr = isWrite(busReq, `SPC_OFS_TEST);
        wdogWr = isWrite(busReq, `SPC_OFS_WDOG);
    end

    // Register writes; reserved bits are R/W and kept as written
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mult_q <= `SPC_RST_MULT;
        end else if (multWr) begin
            mult_q <= busReq.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rate_q <= `SPC_RST_RATE;
        end else if (rateWr) begin
            rate_q <= busReq.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            vco_q <= `SPC_RST_VCO;
        end else if (vcoWr) begin
            vco_q <= busReq.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_q <= `SPC_RST_SYNC;
        end else if (syncWr) begin
            sync_q <= busReq.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            test_q <= `SPC_RST_TEST;
        end else if (testWr) begin
            test_q <= busReq.wdata;
        end
    end

    // Written freely; the counter picks up new fields on the next cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdog_q <= `SPC_RST_WDOG;
        end else if (wdogWr) begin
            wdog_q <= busReq.wdata;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdData_d = `SPC_RD_ZERO;
        case (busReq.addr)
            `SPC_OFS_MULT: rdData_d = mult_q;
            `SPC_OFS_RATE: rdData_d = rate_q;
            `SPC_OFS_VCO: rdData_d = vco_q;
            `SPC_OFS_SYNC: rdData_d = sync_q;
            `SPC_OFS_TEST: rdData_d = test_q;
            `SPC_OFS_WDOG: rdData_d = wdog_q;
            `SPC_OFS_STAT: rdData_d = statusWord(wdState_q == WD_RUN, linkUp, linkEnable);
            default: rdData_d = `SPC_RD_ZERO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdData <= `SPC_RD_ZERO;
        end else if (busReq.rd) begin
            rdData <= rdData_d;
        end else begin
            rdData <= `SPC_RD_ZERO;
        end
    end

    // Decoded configuration toward the PHY
    always_comb begin
        phyCfg_d = '0;
        phyCfg_d.pllFeedbackMultiplier = mult_q;
        phyCfg_d.multLegal = isLegalMult(mult_q);
        phyCfg_d.lineRate = rate_q[`SPC_RATE_HI:0];
        phyCfg_d.lowVcoBandSelect = vco_q[0];
        phyCfg_d.syncRequestN = sync_q[0];
        phyCfg_d.prbsTestSelect = patternOf(test_q[`SPC_TEST_HI:0]);
    end

    // Registered so the PHY never sees a half-decoded word
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phyCfg <= '0;
            phyCfg.pllFeedbackMultiplier <= `SPC_RST_MULT;
            phyCfg.multLegal <= 1'b1;
        end else begin
            phyCfg <= phyCfg_d;
        end
    end

    // Manual request overrides the normal link SYNC
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncOutN <= 1'b1;
        end else begin
            syncOutN <= sync_q[0] ? linkSyncN : 1'b0;
        end
    end

    // Watchdog counts up toward threshold; healthy link drains it
    always_comb begin
        wdLimit = threshold(wdog_q[`SPC_WD_THR_HI:`SPC_WD_THR_LO]);
        wdStep = decStep(wdog_q[`SPC_WD_DEC_HI:`SPC_WD_DEC_LO]);
        wdArmed = linkEnable && (wdLimit != `SPC_WD_ZERO);
        wdHealthy = linkUp && !crcFault;
        // Gated by arming so a disabled watchdog can never fire
        wdFire = (wdState_q == WD_RUN) && wdArmed && (wdCnt_q >= wdLimit);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdState_q <= WD_IDLE;
        end else begin
            case (wdState_q)
                WD_IDLE: begin
                    if (wdArmed) begin
                        wdState_q <= WD_RUN;
                    end
                end
                WD_RUN: begin
                    if (!wdArmed) begin
                        wdState_q <= WD_IDLE;
                    end else if (wdFire) begin
                        wdState_q <= WD_FIRE;
                    end
                end
                WD_FIRE: begin
                    wdState_q <= WD_RUN;
                end
                default: begin
                    wdState_q <= WD_IDLE;
                end
            endcase
        end
    end

    // Counter restarts from zero whenever the watchdog is not counting
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wdCnt_q <= `SPC_WD_ZERO;
        end else if ((wdState_q != WD_RUN) || !wdArmed || wdFire) begin
            wdCnt_q <= `SPC_WD_ZERO;
        end else if (wdHealthy) begin
            // Saturate at zero so a long healthy run cannot wrap
            if (wdCnt_q > wdStep) begin
                wdCnt_q <= wdCnt_q - wdStep;
            end else begin
                wdCnt_q <= `SPC_WD_ZERO;
            end
        end else begin
            wdCnt_q <= wdCnt_q + `SPC_WD_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxResetPulse <= 1'b0;
        end else begin
            rxResetPulse <= wdFire;
        end
    end

    // PLL reset only rides along with a receiver reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pllResetPulse <= 1'b0;
        end else begin
            pllResetPulse <= wdFire && wdog_q[`SPC_WD_PLL_BIT];
        end
    end

endmodule : spc_phy_config_regs
`default_nettype wire

// ---- verification/spc_phy_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_phy_monitor
    import spc_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire spc_bus_req_t busReq, // Bus request
    input wire logic [7:0] rdData, // Read data
    input wire logic linkEnable, // Link enable
    input wire logic linkUp, // Link up
    input wire logic crcFault, // CRC fault
    input wire logic linkSyncN, // Link SYNC
    input wire spc_phy_cfg_t phyCfg, // Decoded config
    input wire logic syncOutN, // SYNC out
    input wire logic rxResetPulse, // Rx reset
    input wire logic pllResetPulse // PLL reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence wr_at(logic [11:0] a);
        busReq.wr && busReq.addr == a;
    endsequence
    a_mult_write: assert property (wr_at(12'h109) |-> ##2
        phyCfg.pllFeedbackMultiplier == $past(busReq.wdata, 2)) else $error("multiplier");
    a_mult_legal: assert property (wr_at(12'h109) |-> ##2 phyCfg.multLegal ==
        ($past(busReq.wdata, 2) inside {8'h10, 8'h14, 8'h21, 8'h28})) else $error("legal");
    a_rate_write: assert property (wr_at(12'h10a) |-> ##2
        phyCfg.lineRate == $past(busReq.wdata[1:0], 2)) else $error("line rate");
    a_test_map: assert property (wr_at(12'h121) |-> ##2 phyCfg.prbsTestSelect ==
        (($past(busReq.wdata[4:0], 2) <= 5'h04) ? spc_pattern_t'($past(busReq.wdata[2:0], 2))
        : PAT_RESERVED)) else $error("pattern");
    a_sync_force: assert property (wr_at(12'h120) ##0 !busReq.wdata[0]
        |-> ##2 !syncOutN) else $error("manual sync");
    a_sync_follow: assert property ($past(rst_b) && phyCfg.syncRequestN
        |-> syncOutN == $past(linkSyncN)) else $error("sync follow");
    a_read_idle: assert property (!busReq.rd |=> rdData == 8'h00) else $error("read idle");
    a_pll_pair: assert property (pllResetPulse |-> rxResetPulse) else $error("pll reset");
    a_rx_single: assert property (rxResetPulse |=> !rxResetPulse) else $error("rx pulse");
endmodule : spc_phy_monitor
bind spc_phy_config_regs spc_phy_monitor mon (.*);
`default_nettype wire

// ---- verification/spc_tx_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spc_tx_model #(
    parameter int LAT = 4 // Cycles to bring the link up
) (
    input wire logic clk, // Clock
    input wire logic rst_b, // Reset
    input wire logic goUp, // Bench asks for link
    input wire logic badCrc, // Bench injects CRC fault
    input wire logic syncOutN, // SYNC request from device
    output logic linkUp, // Link up
    output logic crcFault, // CRC fault
    output logic linkSyncN // Normal-link SYNC
);
    logic [3:0] cnt_q;
    logic linkSyncN_q;
    always_ff @(posedge clk) begin
        linkSyncN_q <= rst_b && goUp;
    end
    // Any SYNC request restarts the link, as a real transmitter would
    always_ff @(posedge clk) begin
        if (!rst_b || !goUp || !syncOutN) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != LAT[3:0]) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    assign linkUp = cnt_q == LAT[3:0] && syncOutN;
    assign crcFault = badCrc && linkUp;
    assign linkSyncN = linkSyncN_q;
endmodule : spc_tx_model
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module testbench
    import spc_pkg::*;
;
    typedef struct packed {logic [11:0] a; logic [7:0] d; logic [7:0] r;} spc_row_t;
    logic clk = 1'b0, rst_b = 1'b0, linkEnable = 1'b0, goUp = 1'b0, badCrc = 1'b0;
    logic linkUp, crcFault, linkSyncN, syncOutN, rxResetPulse, pllResetPulse;
    logic [7:0] rdData, rv;
    spc_bus_req_t busReq = '0;
    spc_phy_cfg_t phyCfg;
    int err_total = 0, comparisons = 0;
    // Address, write data, expected read back; last row is unmapped
    spc_row_t rows[17] = '{28'h109_10_10, 28'h109_14_14, 28'h109_21_21, 28'h109_28_28,
        28'h10a_00_00, 28'h10a_01_01, 28'h10a_02_02, 28'h10a_03_03, 28'h10b_01_01,
        28'h10b_00_00, 28'h121_00_00, 28'h121_01_01, 28'h121_02_02, 28'h121_03_03,
        28'h121_04_04, 28'h124_b4_b4, 28'h1ff_5a_00};
    spc_row_t rr[6] = '{28'h109_00_14, 28'h10a_00_00, 28'h10b_00_00, 28'h120_00_01,
        28'h121_00_00, 28'h124_00_00};
    always #5 clk = ~clk;
    spc_phy_config_regs uut (.clk(clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
        .linkEnable(linkEnable), .linkUp(linkUp), .crcFault(crcFault),
        .linkSyncN(linkSyncN), .phyCfg(phyCfg), .syncOutN(syncOutN),
        .rxResetPulse(rxResetPulse), .pllResetPulse(pllResetPulse));
    spc_tx_model tx (.clk(clk), .rst_b(rst_b), .goUp(goUp), .badCrc(badCrc),
        .syncOutN(syncOutN), .linkUp(linkUp), .crcFault(crcFault), .linkSyncN(linkSyncN));
    task automatic bus(input logic [11:0] a, input logic [7:0] d, input logic w,
        input logic r);
        @(posedge clk) busReq <= '{a, d, w, r};
        @(posedge clk) busReq <= '0;
        #1 rv = rdData;
    endtask : bus
    task automatic do_reset;
        @(posedge clk) rst_b <= 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
    endtask : do_reset
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        do_reset();
        foreach (rows[i]) begin
            bus(rows[i].a, rows[i].d, 1'b1, 1'b0);
            bus(rows[i].a, 8'h00, 1'b0, 1'b1);
            `CHK("readback", rows[i].r, rv)
        end
        $display("register rows done");
        do_reset();
        foreach (rr[i]) begin
            bus(rr[i].a, 8'h00, 1'b0, 1'b1);
            `CHK("reset value", rr[i].r, rv)
        end
        // No link requested yet, so the normal SYNC is asserted
        `CHK("sync after reset", 1'b0, syncOutN)
        $display("reset test done");
        // Write then read with no idle cycle between the strobes
        @(posedge clk) busReq <= '{12'h121, 8'h05, 1'b1, 1'b0};
        @(posedge clk) busReq <= '{12'h121, 8'h00, 1'b0, 1'b1};
        @(posedge clk) busReq <= '0;
        #1 `CHK("back to back read", 8'h05, rdData)
        `CHK("reserved pattern", PAT_RESERVED, phyCfg.prbsTestSelect)
        bus(12'h109, 8'h11, 1'b1, 1'b0);
        @(posedge clk) #1 `CHK("illegal multiplier", 1'b0, phyCfg.multLegal)
        $display("decode test done");
        @(posedge clk) goUp <= 1'b1;
        repeat (10) @(posedge clk);
        #1 `CHK("sync follows link", 1'b1, syncOutN)
        bus(12'h120, 8'h00, 1'b1, 1'b0);
        @(posedge clk) #1 `CHK("manual sync", 1'b0, syncOutN)
        `CHK("link dropped", 1'b0, linkUp)
        bus(12'h120, 8'h01, 1'b1, 1'b0);
        repeat (3) @(posedge clk);
        #1 `CHK("sync released", 1'b1, syncOutN)
        $display("sync test done");
        @(posedge clk) badCrc <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            @(posedge clk) linkEnable <= 1'b0;
            bus(12'h124, 8'h80 | c[7:0], 1'b1, 1'b0);
            @(posedge clk) linkEnable <= 1'b1;
            repeat (3) @(posedge clk);
            bus(12'h130, 8'h00, 1'b0, 1'b1);
            `CHK("watchdog running", {5'h00, c inside {[1:4]}, 2'b11}, rv)
            `CHK("no early expiry", 2'b00, {rxResetPulse, pllResetPulse})
        end
        $display("watchdog test done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
